// ==== verilog/psc_port_ctrl.sv ====
/*
  Per-port operation control and link status register bank for a
  seven-port switch, with each port's loopback data path.
  Assumes the switch core's byte-wide register port (port number in
  the top address nibble), one clock and a synchronous reset.
*/
// Functional notes
// - Local loopback returns fabric egress traffic back into the fabric.
// - Remote loopback returns external receive data out the same port.
// - PHY ports loop line receive pair to line transmit pair.
// - MAC ports loop transmit data inputs to receive data outputs.
// - Host tagging bit marks the port as tail-tagged host port.
// - Queue split: 00 one, 01 two, 10 four queues, 11 reserved.
// - Speed status field: 00 10M, 01 100M, 10 1000M.
// - MAC port speed mirrors external interface speed control bits.
// - PHY port speed shows the actual established link speed.
// - Duplex bit: 1 full; MAC copies setting, PHY shows link.
// - MAC transmit pause status copies transmit pause enable.
// - MAC receive pause status copies receive pause enable.
// - PHY pause status needs advertisement, link up and negotiated pause.
// - Ports one to five are PHY ports, others are MAC ports.
`timescale 1ns/10ps
module psc_port_ctrl import psc_pkg::*; (
  // Clock and reset
  input  wire logic                           sys_clk_i,
  input  wire logic                           sys_rst_i,
  // Register access port
  input  wire logic                           reg_wr_i,
  input  wire logic                           reg_rd_i,
  input  wire logic [ADDR_W-1:0]              reg_addr_i,
  input  wire logic [DATA_W-1:0]              reg_wdata_i,
  output logic      [DATA_W-1:0]              reg_rdata_o,
  output logic                                reg_rvalid_o,
  // Fabric side streams
  input  wire psc_stream_t [NUM_PORTS:1]      fab_egr_i,
  output psc_stream_t      [NUM_PORTS:1]      fab_ing_o,
  // External side streams
  input  wire psc_stream_t [NUM_PORTS:1]      ext_rx_i,
  output psc_stream_t      [NUM_PORTS:1]      ext_tx_o,
  // Status sources
  input  wire psc_phy_state_t [PHY_LAST:1]    phy_state_i,
  input  wire psc_mac_cfg_t [NUM_PORTS:PHY_LAST+1] mac_cfg_i,
  // Configuration outputs to the forwarding logic
  output logic      [NUM_PORTS:1]             host_tag_en_o,
  output psc_qsplit_t [NUM_PORTS:1]           queue_split_o,
  output logic                                host_tag_multi_o
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic [PORT_FIELD_W-1:0] acc_port;
  logic [OFS_W-1:0]        acc_ofs;
  logic                    hit_ctrl;
  logic                    hit_stat;

  assign acc_port = reg_addr_i[PORT_FIELD_LSB +: PORT_FIELD_W];
  assign acc_ofs  = reg_addr_i[OFS_W-1:0];
  assign hit_ctrl = (acc_ofs == OFS_OP_CTRL);
  // Status offset is decoded only for reads, so writes there vanish
  assign hit_stat = (acc_ofs == OFS_LINK_STAT);

  // ----------------------------------------------------------------
  // Per-port registers, status and data path
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] ctrl_reg   [1:NUM_PORTS];
  logic [DATA_W-1:0] stat_reg   [1:NUM_PORTS];
  logic [DATA_W-1:0] stat_next  [1:NUM_PORTS];
  logic [NUM_PORTS:1] tag_bits;

  genvar p;
  generate
    for (p = 1; p <= NUM_PORTS; p++) begin : g_port
      localparam logic [PORT_FIELD_W-1:0] PNUM = PORT_FIELD_W'(p);
      localparam bit IS_PHY = (p <= PHY_LAST);
      psc_phy_state_t phy_src;
      psc_mac_cfg_t   mac_src;

      // Reserved bits are masked off on write so they read zero
      always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
          ctrl_reg[p] <= OP_CTRL_RST;
        end else if (reg_wr_i && hit_ctrl && acc_port == PNUM) begin
          ctrl_reg[p] <= reg_wdata_i & OP_CTRL_WMASK;
        end
      end

      if (IS_PHY) begin : g_phy
        assign phy_src = phy_state_i[p];
        assign mac_src = '0;
      end else begin : g_mac
        assign phy_src = '0;
        assign mac_src = mac_cfg_i[p];
      end

      psc_status_sel #(
        .IS_PHY   (IS_PHY)
      ) u_stat (
        .phy_i    (phy_src),
        .mac_i    (mac_src),
        .status_o (stat_next[p])
      );

      // Status is sampled every cycle; a read sees the prior cycle
      always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
          stat_reg[p] <= DATA_ZERO;
        end else begin
          stat_reg[p] <= stat_next[p];
        end
      end

      psc_port_path u_path (
        .sys_clk_i   (sys_clk_i),
        .sys_rst_i   (sys_rst_i),
        .local_lb_i  (ctrl_reg[p][CTL_LOCAL_LB]),
        .remote_lb_i (ctrl_reg[p][CTL_REMOTE_LB]),
        .fab_egr_i   (fab_egr_i[p]),
        .ext_rx_i    (ext_rx_i[p]),
        .fab_ing_o   (fab_ing_o[p]),
        .ext_tx_o    (ext_tx_o[p])
      );

      always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
          host_tag_en_o[p] <= 1'b0;
          queue_split_o[p] <= PSC_Q_SINGLE;
        end else begin
          host_tag_en_o[p] <= ctrl_reg[p][CTL_HOST_TAG];
          queue_split_o[p] <= psc_qsplit_t'(
            ctrl_reg[p][CTL_QSPLIT_LSB +: QSPLIT_W]);
        end
      end

      assign tag_bits[p] = ctrl_reg[p][CTL_HOST_TAG];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Host tagging conflict
  // ----------------------------------------------------------------
  // Software owns the one-host-port limit; this flag only reports a
  // misconfiguration, it does not arbitrate between ports.
  logic tag_multi;

  always_comb begin
    tag_multi = 1'b0;
    for (int i = 1; i <= NUM_PORTS; i++) begin
      for (int j = i + 1; j <= NUM_PORTS; j++) begin
        if (tag_bits[i] && tag_bits[j]) begin
          tag_multi = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      host_tag_multi_o <= 1'b0;
    end else begin
      host_tag_multi_o <= tag_multi;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] rd_mux;

  always_comb begin
    rd_mux = DATA_ZERO;
    for (int i = 1; i <= NUM_PORTS; i++) begin
      if (acc_port == PORT_FIELD_W'(i)) begin
        if (hit_ctrl) begin
          rd_mux = ctrl_reg[i];
        end else if (hit_stat) begin
          rd_mux = stat_reg[i];
        end
      end
    end
  end

  // Unmapped or out-of-range reads answer zero with rvalid
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      reg_rdata_o  <= DATA_ZERO;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        reg_rdata_o <= rd_mux;
      end
    end
  end

endmodule // psc_port_ctrl

// ==== shared/psc_pkg.sv ====
/*
  Shared constants and types for the per-port operation control and
  link status register bank. Assumes a switch core that supplies one
  clock, a synchronous reset and a byte-wide register access port.
*/
package psc_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int NUM_PORTS      = 7;
  localparam int PHY_LAST       = 5;
  localparam int ADDR_W         = 16;
  localparam int DATA_W         = 8;
  localparam int PORT_FIELD_LSB = 12;
  localparam int PORT_FIELD_W   = 4;
  localparam int OFS_W          = 12;

  // ----------------------------------------------------------------
  // Register offsets within a port page, reset values
  // ----------------------------------------------------------------
  localparam logic [OFS_W-1:0]  OFS_OP_CTRL   = 12'h020;
  localparam logic [OFS_W-1:0]  OFS_LINK_STAT = 12'h030;
  localparam logic [DATA_W-1:0] OP_CTRL_RST   = 8'h00;
  localparam logic [DATA_W-1:0] OP_CTRL_WMASK = 8'hC7;
  localparam logic [DATA_W-1:0] DATA_ZERO     = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTL_LOCAL_LB   = 7;
  localparam int CTL_REMOTE_LB  = 6;
  localparam int CTL_HOST_TAG   = 2;
  localparam int CTL_QSPLIT_LSB = 0;
  localparam int QSPLIT_W       = 2;
  localparam int STAT_SPEED_LSB = 3;
  localparam int STAT_DUPLEX    = 2;
  localparam int STAT_TX_PAUSE  = 1;
  localparam int STAT_RX_PAUSE  = 0;

  // External MAC interface control bits that status mirrors
  localparam int EXT_CTL1_GIG    = 6;
  localparam int EXT_CTL0_FAST   = 4;
  localparam int EXT_CTL0_DUPLEX = 6;
  localparam int EXT_CTL0_TX_PSE = 5;
  localparam int EXT_CTL0_RX_PSE = 3;

  // Negotiation advertisement pause bits
  localparam int ADV_PAUSE_HI = 11;
  localparam int ADV_PAUSE_LO = 10;

  // ----------------------------------------------------------------
  // Encodings and carriers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PSC_SPD_10   = 2'h0,
    PSC_SPD_100  = 2'h1,
    PSC_SPD_1000 = 2'h2
  } psc_speed_t;

  typedef enum logic [1:0] {
    PSC_Q_SINGLE = 2'h0,
    PSC_Q_TWO    = 2'h1,
    PSC_Q_FOUR   = 2'h2,
    PSC_Q_RSVD   = 2'h3
  } psc_qsplit_t;

  typedef struct packed {
    logic              valid;
    logic [DATA_W-1:0] data;
  } psc_stream_t;

  typedef struct packed {
    logic [DATA_W-1:0] ctl1;
    logic [DATA_W-1:0] ctl0;
  } psc_mac_cfg_t;

  typedef struct packed {
    logic        link_up;
    psc_speed_t  speed;
    logic        full_duplex;
    logic [15:0] adv;
    logic        tx_pause_ok;
    logic        rx_pause_ok;
  } psc_phy_state_t;

endpackage

// ==== verilog/psc_port_path.sv ====
/*
  One port's loopback data path between switch fabric and external
  interface. Assumes byte streams synchronous to the core clock.
*/
`timescale 1ns/10ps
module psc_port_path import psc_pkg::*; (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        sys_rst_i,
  // Mode
  input  wire logic        local_lb_i,
  input  wire logic        remote_lb_i,
  // Streams
  input  wire psc_stream_t fab_egr_i,
  input  wire psc_stream_t ext_rx_i,
  output psc_stream_t      fab_ing_o,
  output psc_stream_t      ext_tx_o
);

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      fab_ing_o <= '0;
    end else if (local_lb_i) begin
      fab_ing_o <= fab_egr_i;
    end else if (remote_lb_i) begin
      // External receive never reaches the fabric in remote loopback
      fab_ing_o <= '0;
    end else begin
      fab_ing_o <= ext_rx_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      ext_tx_o <= '0;
    end else if (remote_lb_i) begin
      ext_tx_o <= ext_rx_i;
    end else if (local_lb_i) begin
      ext_tx_o <= '0;
    end else begin
      ext_tx_o <= fab_egr_i;
    end
  end

endmodule // psc_port_path

// ==== verilog/psc_status_sel.sv ====
/*
  Combinational link status byte for one port: negotiated state on
  integrated-PHY ports, mirrored configuration on external MAC ports.
*/
`timescale 1ns/10ps
module psc_status_sel import psc_pkg::*; #(
  parameter bit IS_PHY = 1'b1
) (
  // Sources
  input  wire psc_phy_state_t    phy_i,
  input  wire psc_mac_cfg_t      mac_i,
  // Status byte
  output logic [DATA_W-1:0]      status_o
);

  logic       adv_pause;
  psc_speed_t mac_speed;

  assign adv_pause = phy_i.adv[ADV_PAUSE_HI] | phy_i.adv[ADV_PAUSE_LO];
  assign mac_speed = mac_i.ctl1[EXT_CTL1_GIG] ? PSC_SPD_1000 :
                     (mac_i.ctl0[EXT_CTL0_FAST] ? PSC_SPD_100
                                                : PSC_SPD_10);

  always_comb begin
    status_o = DATA_ZERO;
    if (IS_PHY) begin
      status_o[STAT_SPEED_LSB +: 2] = phy_i.speed;
      status_o[STAT_DUPLEX]         = phy_i.full_duplex;
      status_o[STAT_TX_PAUSE]       = adv_pause & phy_i.link_up &
                                      phy_i.tx_pause_ok;
      status_o[STAT_RX_PAUSE]       = adv_pause & phy_i.link_up &
                                      phy_i.rx_pause_ok;
    end else begin
      status_o[STAT_SPEED_LSB +: 2] = mac_speed;
      status_o[STAT_DUPLEX]         = mac_i.ctl0[EXT_CTL0_DUPLEX];
      status_o[STAT_TX_PAUSE]       = mac_i.ctl0[EXT_CTL0_TX_PSE];
      status_o[STAT_RX_PAUSE]       = mac_i.ctl0[EXT_CTL0_RX_PSE];
    end
  end

endmodule // psc_status_sel

// ==== sim/psc_port_ctrl_sva.sv ====
/*
  Checker for the port control register bank, bound to its top.
  Assumes the top's single clock and synchronous active-high reset.
*/
`timescale 1ns/10ps
module psc_port_ctrl_sva import psc_pkg::*; (
  // Clock and reset
  input wire logic                           sys_clk_i,
  input wire logic                           sys_rst_i,
  // Register port
  input wire logic                           reg_wr_i,
  input wire logic                           reg_rd_i,
  input wire logic [ADDR_W-1:0]              reg_addr_i,
  input wire logic [DATA_W-1:0]              reg_wdata_i,
  input wire logic [DATA_W-1:0]              reg_rdata_o,
  input wire logic                           reg_rvalid_o,
  // Sources and configuration
  input wire psc_phy_state_t [PHY_LAST:1]    phy_state_i,
  input wire psc_mac_cfg_t [NUM_PORTS:PHY_LAST+1] mac_cfg_i,
  input wire logic [NUM_PORTS:1]             host_tag_en_o,
  input wire psc_qsplit_t [NUM_PORTS:1]      queue_split_o
);
  // ----------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------
  wire w4 = reg_wr_i && reg_addr_i == 16'h4020;
  wire w7 = reg_wr_i && reg_addr_i == 16'h7020;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  // A second write in the gap reaches the output a cycle after the check
  sequence wr4_s; w4 ##1 !w4; endsequence
  sequence wr7_s; w7 ##1 !w7; endsequence
  // Status is judged only on sources held across the sample point
  sequence stat_rd_s(a, x);
    reg_rd_i && reg_addr_i == a && $stable(x) && !$past(sys_rst_i);
  endsequence
  // ----------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------
  reserved_zero_a: assert property (reg_rvalid_o |-> !reg_rdata_o[5])
    else $error("reserved read bit set");
  unmapped_read_a: assert property (
    reg_rd_i && reg_addr_i[11:0] == 12'h040
    |=> reg_rvalid_o && reg_rdata_o == 8'h00) else $error("unmapped read");
  tag_write_a: assert property (wr4_s |=>
    host_tag_en_o[4] == $past(reg_wdata_i[2], 2)) else $error("tag not set");
  split_write_a: assert property (wr7_s |=>
    queue_split_o[7] == $past(reg_wdata_i[1:0], 2)) else $error("split wrong");
  mac_duplex_a: assert property (stat_rd_s(16'h6030, mac_cfg_i[6]) |=>
    reg_rdata_o[2] == $past(mac_cfg_i[6].ctl0[6], 2)) else $error("duplex");
  mac_speed_a: assert property (stat_rd_s(16'h7030, mac_cfg_i[7]) |=>
    reg_rdata_o[4:3] == ($past(mac_cfg_i[7].ctl1[6], 2) ? 2'h2
    : {1'b0, $past(mac_cfg_i[7].ctl0[4], 2)})) else $error("mac speed");
  phy_speed_a: assert property (stat_rd_s(16'h1030, phy_state_i[1]) |=>
    reg_rdata_o[4:3] == $past(phy_state_i[1].speed, 2)) else $error("speed");
  phy_pause_a: assert property (stat_rd_s(16'h3030, phy_state_i[3]) |=>
    !reg_rdata_o[1] || $past(phy_state_i[3].link_up, 2)) else $error("pause");
  reset_clear_a: assert property (disable iff (1'b0) sys_rst_i |=>
    !reg_rvalid_o && host_tag_en_o == '0 && queue_split_o == '0)
    else $error("outputs not cleared");
endmodule // psc_port_ctrl_sva

bind psc_port_ctrl psc_port_ctrl_sva u_psc_port_ctrl_sva (
  .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
  .phy_state_i(phy_state_i), .mac_cfg_i(mac_cfg_i),
  .host_tag_en_o(host_tag_en_o), .queue_split_o(queue_split_o));

// ==== sim/psc_port_ctrl_test.sv ====
/*
  Self-checking bench for the port control register bank.
  Assumes a 200 MHz clock; inputs change on the falling edge.
*/
`timescale 1ns/10ps
module psc_port_ctrl_test import psc_pkg::*;;
  logic                            sys_clk = 1'b0;
  logic                            sys_rst = 1'b1;
  logic                            wr = 1'b0;
  logic                            rd = 1'b0;
  logic [ADDR_W-1:0]               addr = '0;
  logic [DATA_W-1:0]               wdata = '0;
  logic [DATA_W-1:0]               rdata;
  logic                            rvalid;
  psc_stream_t [NUM_PORTS:1]       fab_egr = '0;
  psc_stream_t [NUM_PORTS:1]       fab_ing;
  psc_stream_t [NUM_PORTS:1]       ext_rx = '0;
  psc_stream_t [NUM_PORTS:1]       ext_tx;
  psc_phy_state_t [PHY_LAST:1]     phy = '0;
  psc_mac_cfg_t [NUM_PORTS:PHY_LAST+1] mac = '0;
  logic [NUM_PORTS:1]              tag_en;
  psc_qsplit_t [NUM_PORTS:1]       qsplit;
  logic                            tag_multi;
  int                              n_mismatch = 0;
  int                              n_tests = 0;

  always #2.5 sys_clk = ~sys_clk;

  psc_port_ctrl u_psc_port_ctrl (
    .sys_clk_i(sys_clk), .sys_rst_i(sys_rst), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .fab_egr_i(fab_egr),
    .fab_ing_o(fab_ing), .ext_rx_i(ext_rx), .ext_tx_o(ext_tx),
    .phy_state_i(phy), .mac_cfg_i(mac), .host_tag_en_o(tag_en),
    .queue_split_o(qsplit), .host_tag_multi_o(tag_multi));

  // ----------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge sys_clk);
    wr = 1'b0;
  endtask

  // Returns the valid flag above the read byte
  task automatic rd_reg(input logic [15:0] a, output logic [8:0] v);
    @(negedge sys_clk);
    rd = 1'b1;
    addr = a;
    @(negedge sys_clk);
    rd = 1'b0;
    v = {rvalid, rdata};
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  task automatic t_reset;
    logic [8:0] v;
    for (int p = 1; p <= NUM_PORTS; p++) begin
      rd_reg({4'(p), OFS_OP_CTRL}, v);
      check(v, {1'b1, OP_CTRL_RST});
    end
    check({tag_multi, tag_en, qsplit}, '0);
  endtask

  // Every split code, tag on four ports at once, reserved bits written
  task automatic t_ctrl;
    logic [8:0] v;
    for (int c = 0; c < 4; c++) begin
      wr_reg({4'(c + 4), OFS_OP_CTRL}, 8'hFC | 8'(c));
      rd_reg({4'(c + 4), OFS_OP_CTRL}, v);
      check(v, {1'b1, 8'hC4 | 8'(c)});
      check(qsplit[c + 4], c[1:0]);
    end
    check({tag_multi, tag_en}, 8'hF8);
    for (int p = 4; p <= 7; p++) begin
      wr_reg({4'(p), OFS_OP_CTRL}, 8'h00);
    end
    rd_reg({4'h7, OFS_OP_CTRL}, v);
    check({tag_multi, tag_en}, 8'h00);
  endtask

  // Mode bit 1 is local, bit 0 remote; bytes change every cycle
  task automatic t_loop(input int p);
    for (int m = 0; m < 4; m++) begin
      wr_reg({4'(p), OFS_OP_CTRL}, {m[1], m[0], 6'h00});
      repeat (2) @(negedge sys_clk);
      for (int k = 0; k < 3; k++) begin
        fab_egr[p] = {1'b1, 8'(16 * m + k)};
        ext_rx[p] = {1'b1, 8'(8'hA0 + 16 * m + k)};
        @(negedge sys_clk);
        check(fab_ing[p], m[1] ? fab_egr[p] : (m[0] ? '0 : ext_rx[p]));
        check(ext_tx[p],
              m[0] ? ext_rx[p] : (m[1] ? '0 : fab_egr[p]));
      end
    end
    fab_egr[p] = '0;
    ext_rx[p] = '0;
    wr_reg({4'(p), OFS_OP_CTRL}, 8'h00);
  endtask

  task automatic t_mac;
    logic [8:0] v;
    logic [7:0] c0;
    logic [7:0] c1;
    logic [8:0] e;
    for (int k = 0; k < 8; k++) begin
      c0 = {1'b1, k[0], k[1], k[2], k[0], 3'h7};
      c1 = {k[0], k[1] & k[2], 6'h3F};
      mac[6] = {c1, c0};
      mac[7] = {c1, c0};
      repeat (2) @(negedge sys_clk);
      for (int p = 6; p <= 7; p++) begin
        rd_reg({4'(p), OFS_LINK_STAT}, v);
        e = {4'h8, c1[6] ? 2'h2 : {1'b0, c0[4]}, c0[6], c0[5], c0[3]};
        check(v, e);
      end
    end
  endtask

  task automatic t_phy;
    logic [8:0] v;
    logic       ln;
    logic       pa;
    for (int k = 0; k < 10; k++) begin
      ln = k[0] | k[3];
      pa = (k[2] | k[3]) & ln;
      phy[1 + k % 5] = {ln, 2'(k % 3), k[1], 4'h0, k[2], k[3], 10'h155,
                        ~k[1], 1'b1};
      repeat (2) @(negedge sys_clk);
      rd_reg({4'(1 + k % 5), OFS_LINK_STAT}, v);
      check(v, {4'h8, 2'(k % 3), k[1], pa & ~k[1], pa});
    end
  endtask

  task automatic t_refuse;
    logic [8:0] v;
    mac[6] = '0;
    wr_reg({4'h6, OFS_LINK_STAT}, 8'hFF);
    rd_reg({4'h6, OFS_LINK_STAT}, v);
    check(v, 9'h100);
    wr_reg(16'h0020, 8'h84);
    wr_reg(16'h8020, 8'h84);
    rd_reg(16'h3040, v);
    check(v, 9'h100);
    rd_reg(16'h0020, v);
    check({v, tag_en}, {9'h100, 7'h00});
  endtask

  // ----------------------------------------------------------
  // Run and watchdog
  // ----------------------------------------------------------
  initial begin
    repeat (16) @(negedge sys_clk);
    sys_rst = 1'b0;
    t_reset;
    t_ctrl;
    t_loop(1);
    t_loop(6);
    t_mac;
    t_phy;
    t_refuse;
    test_done;
  end

  // All scenarios need well under a thousand cycles
  initial begin
    #20000;
    n_mismatch++;
    test_done;
  end
endmodule // psc_port_ctrl_test
